// *** src/bas_params.svh ***
`ifndef BAS_PARAMS_SVH
`define BAS_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets on the control link
// ---------------------------------------------------------------
`define BAS_ADDR_STAT2 16'h00c2
`define BAS_ADDR_MASK2 16'h00c3
`define BAS_ADDR_STATUS 16'h00d0
`define BAS_BRIDGE_BASE 16'h1000

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define BAS_BIT_LATE 2
`define BAS_BIT_TMO 1
`define BAS_ST_LAST_LATE 3
`define BAS_ST_IN_PROG 2
`define BAS_ST_DONE 1
`define BAS_ST_RDY 0
`define BAS_MASK2_RST 8'h00
`define BAS_STAT2_RST 8'h00
`define BAS_EVT_BITS 8'h06

// ---------------------------------------------------------------
// timing counts
// ---------------------------------------------------------------
`define BAS_LATE_CYCLES 8

`endif

// *** src/bas_pkg.sv ***
package bas_pkg;

  // command answer codes on the link
  typedef enum logic [1:0] {
    BAS_RSP_IGNORED = 2'b00,
    BAS_RSP_OK = 2'b01,
    BAS_RSP_FAIL = 2'b10,
    BAS_RSP_RSVD = 2'b11
  } bas_resp_t;

  // link side bridge tracking
  typedef enum logic [1:0] {
    BAS_L_IDLE = 2'b00,
    BAS_L_WAIT = 2'b01,
    BAS_L_BUSY = 2'b10
  } bas_link_st_t;

  // bus side sequencing
  typedef enum logic [1:0] {
    BAS_A_IDLE = 2'b00,
    BAS_A_SETUP = 2'b01,
    BAS_A_ACCESS = 2'b10
  } bas_apb_st_t;

endpackage

// *** src/bas_bridge_if.sv ***
`timescale 1ns/1ps
// request and answer between link domain and bus domain
interface bas_bridge_if;
  logic req_tgl;
  logic wr;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic ack_tgl;
  logic [7:0] rdata;
  logic err;
  modport link (output req_tgl, wr, addr, wdata, input ack_tgl, rdata, err);
  modport sys (input req_tgl, wr, addr, wdata, output ack_tgl, rdata, err);
endinterface

// *** src/bas_apb_xfer.sv ***
`timescale 1ns/1ps
`include "bas_params.svh"
module bas_apb_xfer (
  input wire logic clk_in, // bus clock
  input wire logic rst_n_in, // async reset, active low
  bas_bridge_if.sys bif, // crossing from link side
  output logic [15:0] paddr_out, // bus address
  output logic psel_out, // bus select
  output logic penable_out, // bus enable
  output logic pwrite_out, // bus write
  output logic [7:0] pwdata_out, // bus write data
  input wire logic [7:0] prdata_in, // bus read data
  input wire logic pready_in, // bus ready
  input wire logic pslverr_in // bus error, taken as timeout
);
  import bas_pkg::*;

  bas_apb_st_t st_q, st_d;
  logic req_s1_q, req_s2_q, req_s3_q;
  logic req_s1_d, req_s2_d, req_s3_d;
  logic ack_q, ack_d, err_q, err_d;
  logic [7:0] rdata_q, rdata_d, pwdata_q, pwdata_d;
  logic [15:0] paddr_q, paddr_d;
  logic psel_q, psel_d, pen_q, pen_d, pwr_q, pwr_d;

  // ---------------------------------------------------------------
  // bus sequencing
  // ---------------------------------------------------------------
  // next values: request sync, setup, access, toggle answer
  always_comb begin
    st_d = st_q;
    req_s1_d = bif.req_tgl;
    req_s2_d = req_s1_q;
    req_s3_d = req_s2_q;
    ack_d = ack_q;
    err_d = err_q;
    rdata_d = rdata_q;
    paddr_d = paddr_q;
    pwdata_d = pwdata_q;
    pwr_d = pwr_q;
    psel_d = psel_q;
    pen_d = pen_q;
    case (st_q)
      BAS_A_IDLE: begin
        if (req_s2_q ^ req_s3_q) begin
          paddr_d = bif.addr;
          pwdata_d = bif.wdata;
          pwr_d = bif.wr;
          psel_d = 1'b1;
          st_d = BAS_A_SETUP;
        end
      end
      BAS_A_SETUP: begin
        pen_d = 1'b1;
        st_d = BAS_A_ACCESS;
      end
      BAS_A_ACCESS: begin
        if (pready_in) begin
          psel_d = 1'b0;
          pen_d = 1'b0;
          rdata_d = prdata_in;
          err_d = pslverr_in;
          ack_d = ~ack_q;
          st_d = BAS_A_IDLE;
        end
      end
      default: begin
        st_d = BAS_A_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= BAS_A_IDLE;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 8'h00;
      paddr_q <= 16'h0000;
      pwdata_q <= 8'h00;
      pwr_q <= 1'b0;
      psel_q <= 1'b0;
      pen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_s1_q <= req_s1_d;
      req_s2_q <= req_s2_d;
      req_s3_q <= req_s3_d;
      ack_q <= ack_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
      paddr_q <= paddr_d;
      pwdata_q <= pwdata_d;
      pwr_q <= pwr_d;
      psel_q <= psel_d;
      pen_q <= pen_d;
    end
  end

  assign bif.ack_tgl = ack_q;
  assign bif.rdata = rdata_q;
  assign bif.err = err_q;
  assign paddr_out = paddr_q;
  assign psel_out = psel_q;
  assign penable_out = pen_q;
  assign pwrite_out = pwr_q;
  assign pwdata_out = pwdata_q;

  // setup phase is always followed by access phase
  AST_APB_SETUP_ACCESS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (psel_q && !pen_q) |=> (psel_q && pen_q))
    else $error("bus setup not followed by access");

endmodule // bas_apb_xfer

// *** src/bas_bridge_status.sv ***
`timescale 1ns/1ps
`include "bas_params.svh"
// What this block does
// (RL1) late read event gated by mask bit 2
// (RL2) late mask cleared by reset, sync loss
// (RL3) timeout event gated by mask bit 1
// (RL4) timeout mask resets to zero
// (RL5) status bit 3 shows late read
// (RL6) late bit cleared on new bus transaction
// (RL7) late condition also sets sticky flag
// (RL8) status bit 2 shows bridge busy
// (RL9) only addresses from 0x1000 use bridge
// (RL10) status bit 1 shows access completed
// (RL11) done cleared when bridge access starts
// (RL12) done cleared on prefetched read answer
// (RL13) status bit 0 shows held read data
// (RL14) ready cleared on a prefetched read answer and on a bridge read start
// (RL15) ready low while fetch in flight
// (RL16) late flag sticky, write one clears
// (RL17) late answer uses selected response code
// (RL18) interrupt is OR of masked flags
module bas_bridge_status #(
  parameter int LATE_CYCLES = `BAS_LATE_CYCLES // link cycles before a read is late
) (
  input wire logic clk_in, // bus clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic link_clk_in, // control link clock
  input wire logic sync_lost_in, // frame sync lost, link domain
  input wire logic cmd_valid_in, // control word command strobe
  input wire logic cmd_write_in, // command is a write
  input wire logic [15:0] cmd_addr_in, // command address
  input wire logic [7:0] cmd_wdata_in, // command write data
  input wire bas_pkg::bas_resp_t late_resp_sel_in, // answer code for late reads
  output logic rsp_valid_out, // answer strobe
  output bas_pkg::bas_resp_t rsp_code_out, // answer code
  output logic [7:0] rsp_rdata_out, // answer read data
  output logic irq_out, // block interrupt, link domain
  output logic [15:0] paddr_out, // bus address
  output logic psel_out, // bus select
  output logic penable_out, // bus enable
  output logic pwrite_out, // bus write
  output logic [7:0] pwdata_out, // bus write data
  input wire logic [7:0] prdata_in, // bus read data
  input wire logic pready_in, // bus ready
  input wire logic pslverr_in // bus error
);
  import bas_pkg::*;

  bas_bridge_if bif ();

  bas_link_st_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic req_tgl_q, req_tgl_d, wr_q, wr_d;
  logic [15:0] addr_q, addr_d, last_addr_q, last_addr_d;
  logic [7:0] wdata_q, wdata_d, held_q, held_d;
  logic ack_s1_q, ack_s2_q, ack_s3_q;
  logic ack_s1_d, ack_s2_d, ack_s3_d;
  logic last_late_q, last_late_d, done_q, done_d, rdy_q, rdy_d;
  logic [7:0] mask_q, mask_d, flag_q, flag_d;
  logic rsp_valid_q, rsp_valid_d, irq_q, irq_d;
  bas_resp_t rsp_code_q, rsp_code_d;
  logic [7:0] rsp_data_q, rsp_data_d;
  logic [7:0] flag_set, flag_clr, status_byte, rd_mux;
  logic ack_ev, bridge_cmd, internal_cmd, prefetch_hit, start_ev, late_ev;

  // ---------------------------------------------------------------
  // decode of incoming commands
  // ---------------------------------------------------------------
  // split bridge range from link registers, spot prefetched hits
  assign ack_ev = ack_s2_q ^ ack_s3_q;
  assign bridge_cmd = cmd_valid_in && (cmd_addr_in >= `BAS_BRIDGE_BASE); // RL9
  assign internal_cmd = cmd_valid_in && (cmd_addr_in < `BAS_BRIDGE_BASE); // RL9
  assign prefetch_hit = bridge_cmd && !cmd_write_in && rdy_q && (cmd_addr_in == last_addr_q);
  assign start_ev = (st_q == BAS_L_IDLE) && bridge_cmd && !prefetch_hit;
  assign late_ev = (st_q == BAS_L_WAIT) && !ack_ev && (cnt_q == 8'(LATE_CYCLES - 1));
  assign status_byte = {4'h0, last_late_q, (st_q != BAS_L_IDLE), done_q, rdy_q}; // RL8

  // read data of link registers
  always_comb begin
    rd_mux = 8'h00;
    case (cmd_addr_in)
      `BAS_ADDR_STATUS: begin
        rd_mux = status_byte;
      end
      `BAS_ADDR_MASK2: begin
        rd_mux = mask_q;
      end
      `BAS_ADDR_STAT2: begin
        rd_mux = flag_q;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // bridge tracking and status
  // ---------------------------------------------------------------
  // next values of tracking state, status bits and answers
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    req_tgl_d = req_tgl_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    last_addr_d = last_addr_q;
    held_d = held_q;
    ack_s1_d = bif.ack_tgl;
    ack_s2_d = ack_s1_q;
    ack_s3_d = ack_s2_q;
    last_late_d = last_late_q;
    done_d = done_q;
    rdy_d = rdy_q;
    rsp_valid_d = 1'b0;
    rsp_code_d = rsp_code_q;
    rsp_data_d = rsp_data_q;
    flag_set = 8'h00;
    flag_clr = 8'h00;
    mask_d = mask_q;
    // link registers answer in idle and busy, not while a read waits
    if (internal_cmd && (st_q != BAS_L_WAIT)) begin
      rsp_valid_d = 1'b1;
      rsp_code_d = BAS_RSP_OK;
      rsp_data_d = cmd_write_in ? 8'h00 : rd_mux;
      if (cmd_write_in && (cmd_addr_in == `BAS_ADDR_MASK2)) begin
        mask_d = cmd_wdata_in & `BAS_EVT_BITS; // RL1 RL3
      end
      if (cmd_write_in && (cmd_addr_in == `BAS_ADDR_STAT2)) begin
        flag_clr = cmd_wdata_in & `BAS_EVT_BITS; // RL16
      end
    end
    case (st_q)
      BAS_L_IDLE: begin
        if (prefetch_hit) begin
          rsp_valid_d = 1'b1;
          rsp_code_d = BAS_RSP_OK;
          rsp_data_d = held_q;
          done_d = 1'b0; // RL12
          rdy_d = 1'b0; // RL14
        end else if (start_ev) begin
          req_tgl_d = ~req_tgl_q;
          wr_d = cmd_write_in;
          addr_d = cmd_addr_in;
          wdata_d = cmd_wdata_in;
          cnt_d = 8'h00;
          done_d = 1'b0; // RL11
          last_late_d = 1'b0; // RL6
          if (cmd_write_in) begin
            rsp_valid_d = 1'b1;
            rsp_code_d = BAS_RSP_OK;
            rsp_data_d = 8'h00;
            st_d = BAS_L_BUSY;
          end else begin
            rdy_d = 1'b0; // RL14
            last_addr_d = cmd_addr_in; // RL13
            st_d = BAS_L_WAIT;
          end
        end
      end
      BAS_L_WAIT: begin
        if (ack_ev) begin
          rsp_valid_d = 1'b1;
          rsp_code_d = bif.err ? BAS_RSP_FAIL : BAS_RSP_OK;
          rsp_data_d = bif.rdata;
          done_d = 1'b1; // RL10
          flag_set[`BAS_BIT_TMO] = bif.err;
          st_d = BAS_L_IDLE;
        end else if (late_ev) begin
          rsp_valid_d = 1'b1;
          rsp_code_d = late_resp_sel_in; // RL17
          rsp_data_d = 8'h00;
          last_late_d = 1'b1; // RL5
          flag_set[`BAS_BIT_LATE] = 1'b1; // RL7
          st_d = BAS_L_BUSY;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      BAS_L_BUSY: begin
        if (bridge_cmd) begin
          rsp_valid_d = 1'b1;
          rsp_code_d = BAS_RSP_FAIL;
          rsp_data_d = 8'h00;
        end
        if (ack_ev) begin
          done_d = 1'b1; // RL10
          flag_set[`BAS_BIT_TMO] = bif.err;
          if (!wr_q && !bif.err) begin
            held_d = bif.rdata;
            rdy_d = 1'b1; // RL13 RL15
          end
          st_d = BAS_L_IDLE;
        end
      end
      default: begin
        st_d = BAS_L_IDLE;
      end
    endcase
    // set wins over a clear in the same cycle
    flag_d = (flag_q & ~flag_clr) | flag_set; // RL16
    if (sync_lost_in) begin
      mask_d[`BAS_BIT_LATE] = 1'b0; // RL2
    end
    irq_d = |(flag_q & mask_q); // RL1 RL3 RL18
  end

  // registers of the link domain
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= BAS_L_IDLE;
      cnt_q <= 8'h00;
      req_tgl_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      last_addr_q <= 16'h0000;
      held_q <= 8'h00;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      last_late_q <= 1'b0;
      done_q <= 1'b0;
      rdy_q <= 1'b0;
      mask_q <= `BAS_MASK2_RST; // RL2 RL4
      flag_q <= `BAS_STAT2_RST;
      rsp_valid_q <= 1'b0;
      rsp_code_q <= BAS_RSP_IGNORED;
      rsp_data_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      req_tgl_q <= req_tgl_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      last_addr_q <= last_addr_d;
      held_q <= held_d;
      ack_s1_q <= ack_s1_d;
      ack_s2_q <= ack_s2_d;
      ack_s3_q <= ack_s3_d;
      last_late_q <= last_late_d;
      done_q <= done_d;
      rdy_q <= rdy_d;
      mask_q <= mask_d;
      flag_q <= flag_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_code_q <= rsp_code_d;
      rsp_data_q <= rsp_data_d;
      irq_q <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // crossing and outputs
  // ---------------------------------------------------------------
  // request fields stay stable until the answer toggle returns
  assign bif.req_tgl = req_tgl_q;
  assign bif.wr = wr_q;
  assign bif.addr = addr_q;
  assign bif.wdata = wdata_q;
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_code_out = rsp_code_q;
  assign rsp_rdata_out = rsp_data_q;
  assign irq_out = irq_q;

  // bus side sequencer in the bus clock domain
  bas_apb_xfer u_xfer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .bif(bif),
    .paddr_out(paddr_out),
    .psel_out(psel_out),
    .penable_out(penable_out),
    .pwrite_out(pwrite_out),
    .pwdata_out(pwdata_out),
    .prdata_in(prdata_in),
    .pready_in(pready_in),
    .pslverr_in(pslverr_in)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // masked late flag drives the interrupt
  AST_IRQ_LATE: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL1
    (flag_q[`BAS_BIT_LATE] && mask_q[`BAS_BIT_LATE]) |=> irq_out)
    else $error("late flag with mask set gave no interrupt");

  // sync loss clears the late mask
  AST_SYNC_CLR_MASK: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL2
    sync_lost_in |=> !mask_q[`BAS_BIT_LATE])
    else $error("late mask survived sync loss");

  // masked timeout flag drives the interrupt
  AST_IRQ_TMO: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL3
    (flag_q[`BAS_BIT_TMO] && mask_q[`BAS_BIT_TMO]) |=> irq_out)
    else $error("timeout flag with mask set gave no interrupt");

  // no masked flag, no interrupt
  AST_IRQ_QUIET: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL18
    ((flag_q & mask_q) == 8'h00) |=> !irq_out)
    else $error("interrupt without masked flag");

  // deadline expiry marks the read late and answers with the selection
  AST_LATE_EXPIRE: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL5 RL17
    late_ev |=> (last_late_q && flag_q[`BAS_BIT_LATE] && rsp_valid_out &&
      (rsp_code_out == $past(late_resp_sel_in))))
    else $error("late read not reported as late");

  // late status and sticky flag rise together
  AST_LATE_FLAG: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL7
    $rose(last_late_q) |-> flag_q[`BAS_BIT_LATE])
    else $error("late status set without late flag");

  // new transaction: busy, not done, not late
  AST_START: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL6 RL8 RL11
    start_ev |=> (status_byte[`BAS_ST_IN_PROG] && !done_q && !last_late_q))
    else $error("bridge start did not update status");

  // link register access leaves the bridge idle
  AST_INTERNAL: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL9
    (internal_cmd && (st_q == BAS_L_IDLE)) |=> (st_q == BAS_L_IDLE) && !done_q == !$past(done_q))
    else $error("link register access touched bridge tracking");

  // completion sets done and ends busy
  AST_DONE: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL10
    (ack_ev && (st_q != BAS_L_IDLE)) |=> (done_q && !status_byte[`BAS_ST_IN_PROG]))
    else $error("completion not shown as done");

  // prefetched answer clears done and ready, returns held data
  AST_PREFETCH: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL12 RL14
    (prefetch_hit && (st_q == BAS_L_IDLE)) |=> (!done_q && !rdy_q && rsp_valid_out &&
      (rsp_rdata_out == $past(held_q))))
    else $error("prefetched read mishandled");

  // late read completing later leaves data ready for its address
  AST_RDY_SET: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL13
    (ack_ev && (st_q == BAS_L_BUSY) && !wr_q && !bif.err) |=> (rdy_q && held_q == $past(bif.rdata)))
    else $error("late read data not held");

  // no ready while a fetch is in flight
  AST_RDY_INFLIGHT: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL15
    (st_q == BAS_L_WAIT) |-> !rdy_q)
    else $error("ready shown during fetch");

  // only a write of one to the late bit clears the sticky flag
  AST_FLAG_STICKY: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // RL16
    (flag_q[`BAS_BIT_LATE] && !(internal_cmd && cmd_write_in &&
      cmd_addr_in == `BAS_ADDR_STAT2 && cmd_wdata_in[`BAS_BIT_LATE])) |=> flag_q[`BAS_BIT_LATE])
    else $error("late flag lost without write one");

endmodule // bas_bridge_status

// *** dv/bas_apb_slave.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// bus memory model with wait states and error answer
// ---------------------------------------------------------------
module bas_apb_slave (
  input wire logic clk_in, // bus clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic psel_in, // bus select
  input wire logic penable_in, // bus enable
  input wire logic pwrite_in, // bus write
  input wire logic [15:0] paddr_in, // bus address
  input wire logic [7:0] pwdata_in, // bus write data
  input wire logic [7:0] wait_in, // wait states per access
  input wire logic err_in, // answer with error
  output logic [7:0] prdata_out, // bus read data
  output logic pready_out, // bus ready
  output logic pslverr_out // bus error
);
  logic [7:0] mem_q [256];
  logic [7:0] cnt_q;
  logic [7:0] last_q;

  // preload a pattern so reads are predictable
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_q[i] = i[7:0] ^ 8'h5a;
    end
  end

  // count wait cycles, store writes, remember last data driven
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 8'h00;
      last_q <= 8'h00;
    end else if (psel_in && penable_in && !pready_out) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      cnt_q <= 8'h00;
      if (pready_out && pwrite_in) begin
        mem_q[paddr_in[7:0]] <= pwdata_in;
      end
      if (pready_out && !pwrite_in) begin
        last_q <= prdata_out;
      end
    end
  end

  // released data bus shows inverse of last value
  assign pready_out = psel_in && penable_in && (cnt_q == wait_in);
  assign pslverr_out = pready_out && err_in;
  assign prdata_out = (pready_out && !pwrite_in) ? mem_q[paddr_in[7:0]] : ~last_q;
endmodule // bas_apb_slave

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import bas_pkg::*;
  logic clk_in, link_clk_in, rst_n_in, sync_lost_in;
  logic cmd_valid_in, cmd_write_in, rsp_valid_out, irq_out;
  logic [15:0] cmd_addr_in;
  logic [15:0] paddr_out;
  logic [7:0] cmd_wdata_in, rsp_rdata_out, pwdata_out, prdata_in, slv_wait, rd;
  logic psel_out, penable_out, pwrite_out, pready_in, pslverr_in, slv_err;
  bas_resp_t late_resp_sel_in, rsp_code_out, rc;
  int mismatches, tests_run, apb_cnt, n0;

  bas_bridge_status #(.LATE_CYCLES(6)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .link_clk_in(link_clk_in), .sync_lost_in(sync_lost_in), .cmd_valid_in(cmd_valid_in),
    .cmd_write_in(cmd_write_in), .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
    .late_resp_sel_in(late_resp_sel_in), .rsp_valid_out(rsp_valid_out),
    .rsp_code_out(rsp_code_out), .rsp_rdata_out(rsp_rdata_out), .irq_out(irq_out),
    .paddr_out(paddr_out), .psel_out(psel_out), .penable_out(penable_out),
    .pwrite_out(pwrite_out), .pwdata_out(pwdata_out), .prdata_in(prdata_in),
    .pready_in(pready_in), .pslverr_in(pslverr_in));

  bas_apb_slave apb_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_out),
    .penable_in(penable_out), .pwrite_in(pwrite_out), .paddr_in(paddr_out),
    .pwdata_in(pwdata_out), .wait_in(slv_wait), .err_in(slv_err), .prdata_out(prdata_in),
    .pready_out(pready_in), .pslverr_out(pslverr_in));

  // ---------------------------------------------------------------
  // clocks, bus transfer counter
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever #40 link_clk_in = ~link_clk_in;
  end
  always @(posedge clk_in) begin
    if (psel_out && penable_out && pready_in) apb_cnt++;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one command, wait for its answer
  task automatic cmd(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge link_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_write_in <= w;
    cmd_addr_in <= a;
    cmd_wdata_in <= d;
    @(posedge link_clk_in);
    cmd_valid_in <= 1'b0;
    n = 0;
    #1;
    while (rsp_valid_out !== 1'b1 && n < 20) begin
      @(posedge link_clk_in);
      #1;
      n++;
    end
    if (rsp_valid_out !== 1'b1) chk8(8'hee, 8'h00);
    rd = rsp_rdata_out;
    rc = rsp_code_out;
  endtask

  task automatic rg(input logic [15:0] a, input logic [7:0] e);
    cmd(1'b0, a, 8'h00);
    chk8(rd, e);
  endtask

  // poll status until the done bit shows
  task automatic wait_done();
    int n;
    n = 0;
    cmd(1'b0, 16'h00d0, 8'h00);
    while (rd[1] !== 1'b1 && n < 30) begin
      cmd(1'b0, 16'h00d0, 8'h00);
      n++;
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rg(16'h00d0, 8'h00);
    rg(16'h00c3, 8'h00);
    rg(16'h00c2, 8'h00);
    chk8({7'h00, irq_out}, 8'h00);
  endtask

  task automatic t_link();
    n0 = apb_cnt;
    cmd(1'b1, 16'h0100, 8'h3c);
    cmd(1'b0, 16'h0fff, 8'h00);
    rg(16'h00d0, 8'h00);
    chk8(apb_cnt[7:0], n0[7:0]);
  endtask

  task automatic t_direct_then_write();
    cmd(1'b0, 16'h1004, 8'h00);
    chk8({6'h00, rc}, 8'h01);
    chk8(rd, 8'h04 ^ 8'h5a);
    rg(16'h00d0, 8'h02);
    slv_wait <= 8'h14;
    cmd(1'b1, 16'h1004, 8'ha5);
    chk8({6'h00, rc}, 8'h01);
    rg(16'h00d0, 8'h04);
    wait_done();
    chk8(rd, 8'h02);
    slv_wait <= 8'h00;
    cmd(1'b0, 16'h1004, 8'h00);
    chk8(rd, 8'ha5);
  endtask

  task automatic t_late();
    cmd(1'b1, 16'h00c3, 8'h06);
    slv_wait <= 8'h28;
    cmd(1'b0, 16'h1010, 8'h00);
    chk8({6'h00, rc}, 8'h01);
    chk8(rd, 8'h00);
    rg(16'h00d0, 8'h0c);
    wait_done();
    chk8(rd, 8'h0b);
    rg(16'h00c2, 8'h04);
    chk8({7'h00, irq_out}, 8'h01);
    @(posedge link_clk_in);
    sync_lost_in <= 1'b1;
    @(posedge link_clk_in);
    sync_lost_in <= 1'b0;
    rg(16'h00c3, 8'h02);
    rg(16'h00c2, 8'h04);
    chk8({7'h00, irq_out}, 8'h00);
    slv_wait <= 8'h00;
    n0 = apb_cnt;
    cmd(1'b0, 16'h1010, 8'h00);
    chk8(rd, 8'h10 ^ 8'h5a);
    chk8(apb_cnt[7:0], n0[7:0]);
    rg(16'h00d0, 8'h08);
    // late read answered with the fail selection
    @(posedge link_clk_in);
    late_resp_sel_in <= BAS_RSP_FAIL;
    slv_wait <= 8'h28;
    cmd(1'b0, 16'h1030, 8'h00);
    chk8({6'h00, rc}, 8'h02);
    wait_done();
    chk8(rd, 8'h0b);
    late_resp_sel_in <= BAS_RSP_OK;
    slv_wait <= 8'h00;
    cmd(1'b1, 16'h00c2, 8'h04);
    rg(16'h00c2, 8'h00);
  endtask

  task automatic t_timeout();
    slv_err <= 1'b1;
    cmd(1'b0, 16'h1020, 8'h00);
    chk8({6'h00, rc}, 8'h02);
    rg(16'h00d0, 8'h02);
    rg(16'h00c2, 8'h02);
    chk8({7'h00, irq_out}, 8'h01);
    cmd(1'b1, 16'h00c3, 8'h00);
    rg(16'h00c3, 8'h00);
    chk8({7'h00, irq_out}, 8'h00);
    slv_err <= 1'b0;
    cmd(1'b1, 16'h00c2, 8'h02);
  endtask

  // ---------------------------------------------------------------
  // verdict, watchdog, main sequence
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    rst_n_in = 1'b0;
    sync_lost_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_write_in = 1'b0;
    cmd_addr_in = 16'h0000;
    cmd_wdata_in = 8'h00;
    late_resp_sel_in = BAS_RSP_OK;
    slv_wait = 8'h00;
    slv_err = 1'b0;
    repeat (4) @(posedge link_clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge link_clk_in);
    t_reset();
    t_link();
    t_direct_then_write();
    t_late();
    t_timeout();
    print_verdict();
  end
endmodule // tb_top
